// >>> verilog/pps_top.sv
`timescale 1ns/1ps
`include "pps_defs.svh"
// Operation
// RULE1: mode bit makes control pins strobe inputs
// RULE2: software sets control directions to input first
// RULE3: input full flag read-only, set by write
// RULE4: control register bit 3 reads zero
// RULE5: bits 2:0 steer control pin directions
// RULE6: reset loads directions ones, control 0000-111
// RULE7: low read strobe while selected reads data
// RULE8: low write strobe while selected writes data
// RULE9: select low enables strobes, high ignores them
// RULE10: data pins are I/O or slave bus
// RULE11: control pins individually directed outside slave mode
// RULE12: processor read returns pin levels
// RULE13: processor write loads output latch
// RULE14: read-modify-write rewrites latch from pin levels
// RULE15: overflow set on second unread external write
// RULE16: input full cleared only by processor read; code also clears it whenever the mode bit is 0
// RULE17: slave mode ignores data direction register
// RULE18: output full clears at external read start; code keeps it set when a processor data write lands in the same cycle
module pps_top
   import pps_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic [7:0]  par_pin_in,
   output logic [7:0]       par_pin_out,
   output logic [7:0]       par_pin_oe,
   input  wire logic [2:0]  ctl_pin_in,
   output logic [2:0]       ctl_pin_out,
   output logic [2:0]       ctl_pin_oe,
   output logic             irq
);
   pps_strb_if sif();

   logic        aw_hold_ff, nxt_aw_hold;
   logic [9:0]  wa_idx_ff, nxt_wa_idx;
   logic        w_hold_ff, nxt_w_hold;
   pps_byte_t   wd_ff, nxt_wd;
   logic        wst_ff, nxt_wst;
   logic        bvalid_ff, nxt_bvalid;
   logic [1:0]  bresp_ff, nxt_bresp;
   logic        rvalid_ff, nxt_rvalid;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [1:0]  rresp_ff, nxt_rresp;
   pps_byte_t   out_latch_ff, nxt_out_latch;
   logic [2:0]  ctl_latch_ff, nxt_ctl_latch;
   pps_byte_t   in_latch_ff, nxt_in_latch;
   pps_byte_t   par_dir_ff, nxt_par_dir;
   logic [2:0]  ctl_dir_ff, nxt_ctl_dir;
   logic        mode_ff, nxt_mode;
   logic        in_full_ff, nxt_in_full;
   logic        out_full_ff, nxt_out_full;
   logic        ovf_ff, nxt_ovf;
   logic [1:0]  stat_ff, nxt_stat;
   logic [1:0]  mask_ff, nxt_mask;
   logic        do_wr;
   logic        do_rd;
   logic [9:0]  rd_idx;
   logic        wr_map;
   logic        rd_map;
   logic [31:0] rd_word;
   logic        sw_wr_par, sw_wr_ctl, sw_wr_pdir, sw_wr_spc, sw_wr_stat, sw_wr_mask;
   logic        sw_rd_par;

   pps_strobe u_strobe (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sif     (sif)
   );

   assign sif.slave_mode = mode_ff;               // see RULE1
   assign sif.ctl_pins   = ctl_pin_in;

   // bus slave: one write and one read in flight, aw and w taken in either order
   assign awready = ~aw_hold_ff & ~bvalid_ff;
   assign wready  = ~w_hold_ff & ~bvalid_ff;
   assign arready = ~rvalid_ff;
   assign do_wr   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   assign do_rd   = arvalid & arready;
   assign rd_idx  = araddr[11:2];
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign rvalid  = rvalid_ff;
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;

   always_comb begin
      wr_map = 1'b0;
      case (wa_idx_ff)
         `PPS_IDX_PAR_DATA, `PPS_IDX_CTL_DATA, `PPS_IDX_PAR_DIR,
         `PPS_IDX_SPC, `PPS_IDX_IRQ_STAT, `PPS_IDX_IRQ_MASK: wr_map = 1'b1;
         default: wr_map = 1'b0;
      endcase
   end

   // only lane 0 carries register bits; a write without it is answered but ignored
   assign sw_wr_par  = do_wr & wst_ff & (wa_idx_ff == `PPS_IDX_PAR_DATA);
   assign sw_wr_ctl  = do_wr & wst_ff & (wa_idx_ff == `PPS_IDX_CTL_DATA);
   assign sw_wr_pdir = do_wr & wst_ff & (wa_idx_ff == `PPS_IDX_PAR_DIR);
   assign sw_wr_spc  = do_wr & wst_ff & (wa_idx_ff == `PPS_IDX_SPC);
   assign sw_wr_stat = do_wr & wst_ff & (wa_idx_ff == `PPS_IDX_IRQ_STAT);
   assign sw_wr_mask = do_wr & wst_ff & (wa_idx_ff == `PPS_IDX_IRQ_MASK);
   assign sw_rd_par  = do_rd & (rd_idx == `PPS_IDX_PAR_DATA);

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_map  = 1'b1;
      case (rd_idx)
         // pins outside slave mode (input latch in slave mode), not the output latch: a read-modify-write copies input levels into the latch
         `PPS_IDX_PAR_DATA: rd_word[7:0] = mode_ff ? in_latch_ff : par_pin_in;   // see RULE12, see RULE14
         `PPS_IDX_CTL_DATA: rd_word[2:0] = ctl_pin_in;                           // see RULE12
         `PPS_IDX_PAR_DIR:  rd_word[7:0] = par_dir_ff;
         `PPS_IDX_SPC:      rd_word[7:0] = {in_full_ff, out_full_ff, ovf_ff, mode_ff, 1'b0, ctl_dir_ff};  // see RULE4
         `PPS_IDX_IRQ_STAT: rd_word[1:0] = stat_ff;
         `PPS_IDX_IRQ_MASK: rd_word[1:0] = mask_ff;
         default:           rd_map       = 1'b0;
      endcase
   end

   always_comb begin
      nxt_aw_hold = aw_hold_ff;
      nxt_wa_idx  = wa_idx_ff;
      nxt_w_hold  = w_hold_ff;
      nxt_wd      = wd_ff;
      nxt_wst     = wst_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rdata   = rdata_ff;
      nxt_rresp   = rresp_ff;
      if (awvalid && awready) begin
         nxt_aw_hold = 1'b1;
         nxt_wa_idx  = awaddr[11:2];
      end
      if (wvalid && wready) begin
         nxt_w_hold = 1'b1;
         nxt_wd     = wdata[7:0];
         nxt_wst    = wstrb[0];
      end
      if (do_wr) begin
         nxt_aw_hold = 1'b0;
         nxt_w_hold  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = wr_map ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
      end
      if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
      if (do_rd) begin
         nxt_rvalid = 1'b1;
         nxt_rdata  = rd_word;
         nxt_rresp  = rd_map ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         wa_idx_ff  <= 10'h000;
         w_hold_ff  <= 1'b0;
         wd_ff      <= 8'h00;
         wst_ff     <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `PPS_RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `PPS_RESP_OKAY;
      end else begin
         aw_hold_ff <= nxt_aw_hold;
         wa_idx_ff  <= nxt_wa_idx;
         w_hold_ff  <= nxt_w_hold;
         wd_ff      <= nxt_wd;
         wst_ff     <= nxt_wst;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         rvalid_ff  <= nxt_rvalid;
         rdata_ff   <= nxt_rdata;
         rresp_ff   <= nxt_rresp;
      end
   end

   // control state; hardware sets win over software clears
   always_comb begin
      nxt_par_dir = par_dir_ff;
      nxt_ctl_dir = ctl_dir_ff;
      nxt_mode     = mode_ff;
      nxt_in_full  = in_full_ff;
      nxt_out_full = out_full_ff;
      nxt_ovf      = ovf_ff;
      nxt_mask    = mask_ff;
      nxt_stat    = stat_ff;
      if (sw_wr_pdir) begin
         nxt_par_dir = wd_ff;
      end
      if (sw_wr_spc) begin
         nxt_mode    = wd_ff[`PPS_BIT_MODE];                   // see RULE1
         nxt_ctl_dir = wd_ff[2:0];                             // see RULE5
         nxt_ovf     = wd_ff[`PPS_BIT_OVF];
      end
      if (sw_wr_mask) begin
         nxt_mask = wd_ff[1:0];
      end
      if (sw_wr_stat) begin
         nxt_stat = stat_ff & ~wd_ff[1:0];
      end
      nxt_stat[`PPS_IRQ_WR] = nxt_stat[`PPS_IRQ_WR] | sif.wr_end;
      nxt_stat[`PPS_IRQ_RD] = nxt_stat[`PPS_IRQ_RD] | sif.rd_end;
      if (sw_rd_par) begin
         nxt_in_full = 1'b0;                                   // see RULE16
      end
      if (sif.wr_end) begin
         nxt_in_full = 1'b1;                                   // see RULE3
      end
      if (sif.wr_end && in_full_ff && !sw_rd_par) begin
         nxt_ovf = 1'b1;                                       // see RULE15
      end
      if (sif.rd_start) begin
         nxt_out_full = 1'b0;                                  // see RULE18
      end
      // fresh firmware data outranks a read that starts in the same cycle
      if (sw_wr_par && mode_ff) begin
         nxt_out_full = 1'b1;                                  // see RULE18
      end
      if (!mode_ff) begin
         nxt_in_full  = 1'b0;
         nxt_out_full = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         par_dir_ff <= `PPS_RST_PAR_DIR;                       // see RULE6
         ctl_dir_ff <= `PPS_RST_CTL_DIR;                       // see RULE6
         mode_ff     <= 1'b0;
         in_full_ff  <= 1'b0;
         out_full_ff <= 1'b0;
         ovf_ff     <= 1'b0;
         mask_ff    <= 2'h0;
         stat_ff    <= 2'h0;
      end else begin
         par_dir_ff <= nxt_par_dir;
         ctl_dir_ff <= nxt_ctl_dir;
         mode_ff     <= nxt_mode;
         in_full_ff  <= nxt_in_full;
         out_full_ff <= nxt_out_full;
         ovf_ff     <= nxt_ovf;
         mask_ff    <= nxt_mask;
         stat_ff    <= nxt_stat;
      end
   end

   // data latches keep their contents through reset, so no reset branch
   always_comb begin
      nxt_out_latch = out_latch_ff;
      nxt_ctl_latch = ctl_latch_ff;
      nxt_in_latch  = in_latch_ff;
      if (sw_wr_par) begin
         nxt_out_latch = wd_ff;                                // see RULE13
      end
      if (sw_wr_ctl) begin
         nxt_ctl_latch = wd_ff[2:0];                           // see RULE13
      end
      if (sif.wr_active) begin
         nxt_in_latch = par_pin_in;                            // see RULE8
      end
   end

   always_ff @(posedge aclk) begin                             // see RULE6
      out_latch_ff <= nxt_out_latch;
      ctl_latch_ff <= nxt_ctl_latch;
      in_latch_ff  <= nxt_in_latch;
   end

   // pins; out is masked by oe so an unset latch reaches the port only where oe is set
   assign par_pin_oe  = mode_ff ? {8{sif.rd_active}} : ~par_dir_ff;     // see RULE10, see RULE17, see RULE7
   assign par_pin_out = out_latch_ff & par_pin_oe;
   assign ctl_pin_oe  = mode_ff ? 3'h0 : ~ctl_dir_ff;                  // see RULE1, see RULE11
   assign ctl_pin_out = ctl_latch_ff & ctl_pin_oe;
   assign irq         = |(stat_ff & mask_ff);

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_mode_ctl_in: assert property (mode_ff |-> ctl_pin_oe == 3'h0)  // see RULE1
      else $error("control pins driven in slave mode");
   chk_ctl_dir: assert property (!mode_ff |-> ctl_pin_oe == ~ctl_dir_ff)  // see RULE5
      else $error("control pin enable differs from direction");
   chk_reset_vals: assert property ($past(!aresetn) |-> par_dir_ff == 8'hFF && ctl_dir_ff == 3'h7 && !mode_ff)  // see RULE6
      else $error("wrong values after reset");
   chk_in_full_set: assert property (sif.wr_end |=> in_full_ff)  // see RULE3
      else $error("input full not set after write");
   chk_in_full_drop: assert property ($fell(in_full_ff) |-> $past(sw_rd_par) || !$past(mode_ff))  // see RULE16
      else $error("input full cleared without read");
   // sticky: only a software write of the control register may drop it
   chk_ovf_set: assert property (sif.wr_end && in_full_ff && !sw_rd_par |=>
                                 ovf_ff ##1 (ovf_ff || $past(sw_wr_spc)))  // see RULE15
      else $error("overflow not set or not sticky");
   chk_out_full_clear: assert property (sif.rd_start && !sw_wr_par |=> !out_full_ff)  // see RULE18
      else $error("output full not cleared at read start");
   chk_bit3_zero: assert property ($past(do_rd) && $past(rd_idx) == `PPS_IDX_SPC |-> rdata[3] == 1'b0 &&
                                   rdata[4] == $past(mode_ff))  // see RULE4
      else $error("control register bit 3 not zero");
   chk_pin_read: assert property ($past(do_rd) && $past(rd_idx) == `PPS_IDX_PAR_DATA && !$past(mode_ff) |->
                                  rdata[7:0] == $past(par_pin_in))  // see RULE12
      else $error("data read not from pins");
   chk_out_latch: assert property (sw_wr_par && !mode_ff |=> par_pin_out == ($past(wd_ff) & ~par_dir_ff))  // see RULE13
      else $error("written byte not on pins");
   chk_slave_oe: assert property (mode_ff |-> par_pin_oe == {8{sif.rd_active}})  // see RULE17
      else $error("data pins not steered by strobes");
   chk_no_desel: assert property (ctl_pin_in[2] |-> !sif.wr_start && !sif.rd_start && !sif.wr_active)  // see RULE9
      else $error("strobe acted while deselected");
   chk_wr_capture: assert property (sif.wr_active |=> in_latch_ff == $past(par_pin_in))  // see RULE8
      else $error("external write not captured");

   cov_wr_then_read: cover property (sif.wr_end ##[1:20] sw_rd_par);
   cov_ext_read: cover property (sif.rd_start ##[1:20] sif.rd_end);
   cov_overflow: cover property ($rose(ovf_ff));
   cov_irq: cover property ($rose(irq));
endmodule

// >>> inc/pps_defs.svh
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH
`define PPS_IDX_PAR_DATA  10'h008
`define PPS_IDX_CTL_DATA  10'h009
`define PPS_IDX_PAR_DIR   10'h088
`define PPS_IDX_SPC       10'h089
`define PPS_IDX_IRQ_STAT  10'h00C
`define PPS_IDX_IRQ_MASK  10'h08C
`define PPS_BIT_IN_FULL   7
`define PPS_BIT_OUT_FULL  6
`define PPS_BIT_OVF       5
`define PPS_BIT_MODE      4
`define PPS_RST_PAR_DIR   8'hFF
`define PPS_RST_CTL_DIR   3'h7
`define PPS_IRQ_WR        0
`define PPS_IRQ_RD        1
`define PPS_RESP_OKAY     2'h0
`define PPS_RESP_SLVERR   2'h2
`endif

// >>> inc/pps_pkg.sv
package pps_pkg;
   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_write = 2'b01,
      st_read  = 2'b10
   } pps_strb_e;
   typedef logic [7:0] pps_byte_t;
endpackage

// >>> inc/pps_strb_if.sv
`timescale 1ns/1ps
interface pps_strb_if;
   logic       slave_mode;
   logic [2:0] ctl_pins;
   logic       wr_active;
   logic       rd_active;
   logic       wr_start;
   logic       wr_end;
   logic       rd_start;
   logic       rd_end;
   modport decoder (input slave_mode, input ctl_pins, output wr_active, output rd_active,
                    output wr_start, output wr_end, output rd_start, output rd_end);
   modport core (output slave_mode, output ctl_pins, input wr_active, input rd_active,
                 input wr_start, input wr_end, input rd_start, input rd_end);
endinterface

// >>> verilog/pps_strobe.sv
`timescale 1ns/1ps
module pps_strobe
   import pps_pkg::*;
(
   input  wire logic   aclk,
   input  wire logic   aresetn,
   pps_strb_if.decoder sif
);
   pps_strb_e state_ff;
   pps_strb_e nxt_state;
   logic      sel;
   logic      wr_sel;
   logic      rd_sel;

   // pins: 2 = select, 1 = write strobe, 0 = read strobe, all active low
   assign sel    = sif.slave_mode & ~sif.ctl_pins[2];    // see RULE9
   assign wr_sel = sel & ~sif.ctl_pins[1];               // see RULE8
   assign rd_sel = sel & ~sif.ctl_pins[0];               // see RULE7

   // a strobe pair held low counts once; the other strobe is locked out meanwhile
   assign sif.wr_active = wr_sel & (state_ff != st_read);
   assign sif.rd_active = rd_sel & (state_ff != st_write);
   assign sif.wr_start  = (state_ff == st_idle) & wr_sel;
   assign sif.rd_start  = (state_ff == st_idle) & ~wr_sel & rd_sel;
   assign sif.wr_end    = (state_ff == st_write) & ~wr_sel & sif.slave_mode;
   assign sif.rd_end    = (state_ff == st_read) & ~rd_sel & sif.slave_mode;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         st_idle: begin
            if (wr_sel) begin
               nxt_state = st_write;
            end else if (rd_sel) begin
               nxt_state = st_read;
            end
         end
         st_write: begin
            if (!wr_sel) begin
               nxt_state = st_idle;
            end
         end
         st_read: begin
            if (!rd_sel) begin
               nxt_state = st_idle;
            end
         end
         default: begin
            nxt_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= st_idle;
      end else begin
         state_ff <= nxt_state;
      end
   end
endmodule

// >>> verification/pps_ext_bus.sv
`timescale 1ns/1ps
module pps_ext_bus
   import pps_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic [7:0] par_pin_out,
   input  wire logic [7:0] par_pin_oe,
   input  wire logic [2:0] ctl_pin_out,
   input  wire logic [2:0] ctl_pin_oe,
   output logic [7:0]      par_pin_in,
   output logic [2:0]      ctl_pin_in
);
   pps_byte_t  ext_data = 8'h00;
   logic [7:0] ext_en   = 8'h00;
   logic [2:0] ext_ctl  = 3'h7;
   pps_byte_t  flt      = 8'h5A;

   // released lines toggle so a stale value never passes for data
   always @(posedge aclk) begin
      flt <= ~flt;
   end

   assign par_pin_in = (par_pin_oe & par_pin_out) | (~par_pin_oe & ext_en & ext_data) | (~par_pin_oe & ~ext_en & flt);
   assign ctl_pin_in = (ctl_pin_oe & ctl_pin_out) | (~ctl_pin_oe & ext_ctl);

   task automatic drive(input pps_byte_t d, input logic [7:0] en, input logic [2:0] c);
      ext_data <= d;
      ext_en   <= en;
      ext_ctl  <= c;
   endtask

   // data held one cycle past the strobe so the last sample is clean
   task automatic bus_write(input pps_byte_t d, input int n);
      @(posedge aclk);
      ext_data <= d;
      ext_en   <= 8'hFF;
      ext_ctl  <= 3'b001;
      repeat (n) @(posedge aclk);
      ext_ctl <= 3'b111;
      @(posedge aclk);
      ext_en <= 8'h00;
   endtask

   task automatic bus_read(output pps_byte_t d, output pps_byte_t oe);
      @(posedge aclk);
      ext_ctl <= 3'b010;
      @(posedge aclk);
      d = par_pin_in;
      oe = par_pin_oe;
      ext_ctl <= 3'b111;
      @(posedge aclk);
   endtask
endmodule

// >>> verification/test_port_pair_with_slave_port_ctrl.sv
`timescale 1ns/1ps
`include "pps_defs.svh"
module test_port_pair_with_slave_port_ctrl
   import pps_pkg::*;
;
   localparam logic [11:0] a_pd  = {`PPS_IDX_PAR_DATA, 2'b00};
   localparam logic [11:0] a_cd  = {`PPS_IDX_CTL_DATA, 2'b00};
   localparam logic [11:0] a_dir = {`PPS_IDX_PAR_DIR, 2'b00};
   localparam logic [11:0] a_spc = {`PPS_IDX_SPC, 2'b00};
   localparam logic [11:0] a_ist = {`PPS_IDX_IRQ_STAT, 2'b00};
   localparam logic [11:0] a_imk = {`PPS_IDX_IRQ_MASK, 2'b00};
   localparam logic [1:0]  ok    = `PPS_RESP_OKAY;

   logic        aclk    = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] awaddr  = 12'h000;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'hF;
   logic        wvalid  = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready  = 1'b0;
   logic [11:0] araddr  = 12'h000;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready  = 1'b0;
   logic [7:0]  par_pin_in;
   logic [7:0]  par_pin_out;
   logic [7:0]  par_pin_oe;
   logic [2:0]  ctl_pin_in;
   logic [2:0]  ctl_pin_out;
   logic [2:0]  ctl_pin_oe;
   logic        irq;
   int          n_fail      = 0;
   int          comparisons = 0;
   pps_byte_t   rd_d;
   pps_byte_t   rd_oe;

   initial begin
      forever #5 aclk = ~aclk;
   end

   pps_top pps_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .par_pin_in(par_pin_in), .par_pin_out(par_pin_out),
      .par_pin_oe(par_pin_oe), .ctl_pin_in(ctl_pin_in), .ctl_pin_out(ctl_pin_out), .ctl_pin_oe(ctl_pin_oe),
      .irq(irq));

   pps_ext_bus pps_ext_bus_inst (.aclk(aclk), .par_pin_out(par_pin_out), .par_pin_oe(par_pin_oe),
      .ctl_pin_out(ctl_pin_out), .ctl_pin_oe(ctl_pin_oe), .par_pin_in(par_pin_in), .ctl_pin_in(ctl_pin_in));

   task automatic stop_test;
      if (n_fail == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang;
      n_fail++;
      $display("ERROR at %0t: bus answer timed out", $time);
      stop_test;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            chk(bresp, er);
            return;
         end
      end
      hang;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            chk(rresp, er);
            chk(rdata, exp);
            return;
         end
      end
      hang;
   endtask

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(par_pin_oe, 32'h0);
      chk(ctl_pin_oe, 32'h0);
      chk(irq, 32'h0);
      rd_chk(a_dir, 32'hFF, ok);
      rd_chk(a_spc, 32'h07, ok);
      wr(a_spc, 32'hCF, ok);
      rd_chk(a_spc, 32'h07, ok);
      // general port: low nibble driven, high nibble from far side
      wr(a_dir, 32'hF0, ok);
      wr(a_pd, 32'hA5, ok);
      pps_ext_bus_inst.drive(8'h30, 8'hF0, 3'b100);
      @(negedge aclk);
      chk(par_pin_oe, 32'h0F);
      chk(par_pin_out, 32'h05);
      rd_chk(a_pd, 32'h35, ok);
      wr(a_pd, 32'hB5, ok);
      pps_ext_bus_inst.drive(8'h00, 8'h00, 3'b100);
      wr(a_dir, 32'h00, ok);
      @(negedge aclk);
      chk(par_pin_out, 32'hB5);
      wr(a_spc, 32'h05, ok);
      wr(a_cd, 32'h07, ok);
      @(negedge aclk);
      chk(ctl_pin_oe, 32'h2);
      chk(ctl_pin_out, 32'h2);
      rd_chk(a_cd, 32'h06, ok);
      // slave port mode, strobes idle high first
      pps_ext_bus_inst.drive(8'h00, 8'h00, 3'b111);
      wr(a_spc, 32'h17, ok);
      wr(a_imk, 32'h03, ok);
      @(negedge aclk);
      chk(ctl_pin_oe, 32'h0);
      chk(par_pin_oe, 32'h0);
      wr(a_pd, 32'h5A, ok);
      rd_chk(a_spc, 32'h57, ok);
      pps_ext_bus_inst.bus_write(8'h3C, 2);
      rd_chk(a_spc, 32'hD7, ok);
      @(negedge aclk);
      chk(irq, 32'h1);
      // both strobes low but deselected: must be ignored
      @(posedge aclk);
      pps_ext_bus_inst.drive(8'h99, 8'hFF, 3'b100);
      repeat (4) @(negedge aclk);
      chk(par_pin_oe, 32'h0);
      @(posedge aclk);
      pps_ext_bus_inst.drive(8'h00, 8'h00, 3'b111);
      rd_chk(a_spc, 32'hD7, ok);
      pps_ext_bus_inst.bus_write(8'h77, 2);
      rd_chk(a_spc, 32'hF7, ok);
      rd_chk(a_pd, 32'h77, ok);
      rd_chk(a_spc, 32'h77, ok);
      pps_ext_bus_inst.bus_read(rd_d, rd_oe);
      chk(rd_oe, 32'hFF);
      chk(rd_d, 32'h5A);
      rd_chk(a_spc, 32'h37, ok);
      rd_chk(a_ist, 32'h03, ok);
      wr(a_ist, 32'h03, ok);
      rd_chk(a_ist, 32'h00, ok);
      chk(irq, 32'h0);
      wr(a_imk, 32'h00, ok);
      pps_ext_bus_inst.bus_write(8'h11, 2);
      rd_chk(a_ist, 32'h01, ok);
      chk(irq, 32'h0);
      wr(a_spc, 32'h17, ok);
      rd_chk(a_spc, 32'h97, ok);
      wr(a_spc, 32'h07, ok);
      rd_chk(a_spc, 32'h07, ok);
      rd_chk(12'h100, 32'h0, `PPS_RESP_SLVERR);
      wr(12'h100, 32'h0, `PPS_RESP_SLVERR);
      // mid-run reset: registers reload, data latch kept
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(par_pin_oe, 32'h0);
      rd_chk(a_spc, 32'h07, ok);
      // lane 0 strobe off: answered but ignored
      wstrb <= 4'h0;
      wr(a_dir, 32'h00, ok);
      rd_chk(a_dir, 32'hFF, ok);
      wstrb <= 4'hF;
      wr(a_dir, 32'h00, ok);
      @(negedge aclk);
      chk(par_pin_out, 32'h5A);
      stop_test;
   end
endmodule
